// [pid_defines.vh]
// Purpose: Shared constants for the PHY identifier register block
// Assumes: Included by bare name from the design files
// Notes:   Definitions only; identity defaults are arbitrary values
`ifndef PID_DEFINES_VH
`define PID_DEFINES_VH

// ****************************************************************
// Management register addresses
// ****************************************************************
`define PID_REG_STATUS      5'h01
`define PID_REG_ID_HIGH     5'h02
`define PID_REG_ID_LOW      5'h03

// ****************************************************************
// Status register content served by this block
// ****************************************************************
`define PID_EXT_CAP_BIT     0
`define PID_STATUS_VALUE    16'h0001

// ****************************************************************
// Identifier field layout
// ****************************************************************
`define PID_HIGH_FIRST_OUI  3
`define PID_LOW_FIRST_OUI   19
`define PID_LOW_OUI_BITS    6
`define PID_MODEL_MSB       9
`define PID_MODEL_LSB       4
`define PID_REV_MSB         3
`define PID_REV_LSB         0

// ****************************************************************
// Identity defaults (arbitrary values, not any maker's codes)
// ****************************************************************
`define PID_OUI_DEFAULT     24'h5a3c96
`define PID_MODEL_DEFAULT   6'h2a
`define PID_REV_DEFAULT     4'h3

// ****************************************************************
// Serial management frame constants
// ****************************************************************
`define PID_OP_READ         2'h2
`define PID_OP_WRITE        2'h1
`define PID_PRE_ONES        6'h20
`define PID_HDR_LAST        5'h0c
`define PID_TA_DRIVE        5'h00
`define PID_DATA_LAST_RD    5'h10
`define PID_FRAME_LAST      5'h11

`endif

// [pid_exp.svh]
// Purpose: Expected identifier layout for the checks
// Assumes: Included inside a module body
// Notes:   Octets left to right, each taken lsb first
// Pack cnt identifier bits from index first, msb down
function automatic [15:0] pid_oui_bits(input [23:0] o,
  input integer first, input integer cnt);
  integer i;
  integer n;
  begin
    pid_oui_bits = 16'h0000;
    for (i = 0; i < cnt; i = i + 1) begin
      n = first + i - 1;
      pid_oui_bits[15 - i] = o[16 - 8 * (n / 8) + n % 8];
    end
  end
endfunction

// [pid_id_bank.v]
// Purpose: Holds the two PHY identifier registers with gated writes
// Assumes: Write strobe is a single-cycle pulse from the frame engine
// Notes:   Defaults are rebuilt from the identity parameters on reset
`timescale 1ns/1ns
`include "pid_defines.vh"

module pid_id_bank #(
  parameter [23:0] OUI   = `PID_OUI_DEFAULT,
  parameter [5:0]  MODEL = `PID_MODEL_DEFAULT,
  parameter [3:0]  REV   = `PID_REV_DEFAULT
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        wr_stb,
  input  wire [4:0]  wr_addr,
  input  wire [15:0] wr_data,
  input  wire        cmd_override_en,
  output reg  [15:0] id_high,
  output reg  [15:0] id_low
);

  // ****************************************************************
  // Identifier bit numbering
  // ****************************************************************

  // Identifier bit n (1..24): octets left to right, each octet lsb first
  function oui_bit;
    input [23:0] oui;
    input integer n;
    integer octet;
    integer pos;
    begin
      octet   = (n - 1) / 8;
      pos     = 16 - 8 * octet + ((n - 1) % 8);
      oui_bit = oui[pos];
    end
  endfunction

  // ****************************************************************
  // Default values
  // ****************************************************************
  wire [15:0] def_high;
  wire [15:0] def_low;

  genvar i;
  generate
    // High register: bit 15 carries identifier bit 3, down to bit 18
    for (i = 0; i < 16; i = i + 1) begin : g_high
      assign def_high[15 - i] =
        oui_bit(OUI, `PID_HIGH_FIRST_OUI + i);
    end
    // Low register top six bits: identifier bits 19 to 24
    for (i = 0; i < `PID_LOW_OUI_BITS; i = i + 1) begin : g_low
      assign def_low[15 - i] =
        oui_bit(OUI, `PID_LOW_FIRST_OUI + i);
    end
  endgenerate

  // Model and revision fields, msb first
  assign def_low[`PID_MODEL_MSB:`PID_MODEL_LSB] = MODEL;
  assign def_low[`PID_REV_MSB:`PID_REV_LSB]     = REV;

  // ****************************************************************
  // Gated register writes
  // ****************************************************************
  wire override_gated_write_bit;
  assign override_gated_write_bit = wr_stb & cmd_override_en;

  // Writes land only while override is set; blocked ones vanish
  always @(posedge clk) begin
    if (sys_rst) begin
      id_high <= def_high;
      id_low  <= def_low;
    end else if (clk_en && override_gated_write_bit) begin
      if (wr_addr == `PID_REG_ID_HIGH)
        id_high <= wr_data;
      if (wr_addr == `PID_REG_ID_LOW)
        id_low <= wr_data;
    end
  end

endmodule

// [pid_phy_id.v]
// Purpose: Serial management slave serving PHY identifier registers
// Assumes: mdc and mdio_in are synchronous to clk and slower than clk/2
// Notes:   Full 32-bit preamble needed; unserved registers read zero
//
// Summary of operation
// - Status register always reports the extended-capability bit as one.
// - Registers 2 and 3 together form one 32-bit PHY identifier.
// - Identifier registers are readable at any time without a condition.
// - Identifier writes take effect only while override enable is one.
// - Register 2 holds identifier bits 3 to 18, bit 3 at top.
// - Identifier bits come from octets left to right, each lsb first.
// - Register 3 bits 15 to 10 hold identifier bits 19 to 24.
// - Register 3 bits 9 to 4 hold the six-bit model number.
// - Register 3 bits 3 to 0 hold the four-bit revision number.
// - With override enable zero, identifier writes leave values unchanged.
`timescale 1ns/1ns
`include "pid_defines.vh"

module pid_phy_id #(
  parameter [23:0] OUI   = `PID_OUI_DEFAULT,
  parameter [5:0]  MODEL = `PID_MODEL_DEFAULT,
  parameter [3:0]  REV   = `PID_REV_DEFAULT
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  input  wire        mdc,
  input  wire        mdio_in,
  output reg         mdio_out,
  output reg         mdio_oe,
  input  wire [4:0]  phy_addr,
  input  wire        cmd_override_en,
  output wire [15:0] id_high,
  output wire [15:0] id_low
);

  // ****************************************************************
  // Frame engine states
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HDR  = 2'b01;
  localparam [1:0] ST_RD   = 2'b10;
  localparam [1:0] ST_WR   = 2'b11;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [1:0]  state;
  reg         mdc_prev;
  reg  [5:0]  ones_cnt;
  reg  [4:0]  bit_cnt;
  reg  [11:0] hdr_sr;
  reg  [15:0] rd_sr;
  reg  [14:0] wr_sr;
  reg         wr_stb;
  reg  [4:0]  wr_addr;
  reg  [15:0] wr_data;

  wire        mdc_rise;
  wire [12:0] next_hdr;
  wire        hdr_start_ok;
  wire [1:0]  hdr_op;
  wire [4:0]  hdr_phy;
  wire [4:0]  hdr_reg;
  wire        hdr_hit;
  wire [15:0] next_wr;

  // ****************************************************************
  // Read data selection
  // ****************************************************************

  // Picks the value served for a register address
  function [15:0] read_value;
    input [4:0]  addr;
    input [15:0] high;
    input [15:0] low;
    begin
      case (addr)
        `PID_REG_STATUS:  read_value = `PID_STATUS_VALUE;
        `PID_REG_ID_HIGH: read_value = high;
        `PID_REG_ID_LOW:  read_value = low;
        default:          read_value = 16'h0000;
      endcase
    end
  endfunction

  // ****************************************************************
  // Clock edge detection and header decode
  // ****************************************************************

  // Sampling point is the rising edge of the management clock
  assign mdc_rise = mdc & ~mdc_prev;

  // Header as it stands once the current bit is shifted in
  assign next_hdr     = {hdr_sr[11:0], mdio_in};
  assign hdr_start_ok = next_hdr[12];
  assign hdr_op       = next_hdr[11:10];
  assign hdr_phy      = next_hdr[9:5];
  assign hdr_reg      = next_hdr[4:0];
  assign hdr_hit      = hdr_start_ok & (hdr_phy == phy_addr);

  // Write data including the bit on the line now
  assign next_wr = {wr_sr[14:0], mdio_in};

  // ****************************************************************
  // Edge history
  // ****************************************************************

  // Previous level of the management clock
  always @(posedge clk) begin
    if (sys_rst)
      mdc_prev <= 1'b0;
    else if (clk_en)
      mdc_prev <= mdc;
  end

  // ****************************************************************
  // Frame engine
  // ****************************************************************

  // Walks preamble, header, turnaround and data of each frame
  always @(posedge clk) begin
    if (sys_rst) begin
      state    <= ST_IDLE;
      ones_cnt <= 6'h00;
      bit_cnt  <= 5'h00;
      hdr_sr   <= 12'h000;
      rd_sr    <= 16'h0000;
      wr_sr    <= 15'h0000;
      wr_stb   <= 1'b0;
      wr_addr  <= 5'h00;
      wr_data  <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      if (mdc_rise) begin
        case (state)
          // Count preamble ones; a zero after 32 is the start bit
          ST_IDLE: begin
            if (mdio_in) begin
              if (ones_cnt != `PID_PRE_ONES)
                ones_cnt <= ones_cnt + 6'h01;
            end else if (ones_cnt == `PID_PRE_ONES) begin
              ones_cnt <= 6'h00;
              bit_cnt  <= 5'h00;
              state    <= ST_HDR;
            end else begin
              ones_cnt <= 6'h00;
            end
          end

          // Second start bit, opcode, PHY and register address
          ST_HDR: begin
            hdr_sr  <= next_hdr[11:0];
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PID_HDR_LAST) begin
              bit_cnt <= 5'h00;
              if (hdr_hit && hdr_op == `PID_OP_READ) begin
                rd_sr <= read_value(hdr_reg, id_high, id_low);
                state <= ST_RD;
              end else if (hdr_hit && hdr_op == `PID_OP_WRITE) begin
                wr_addr <= hdr_reg;
                state   <= ST_WR;
              end else begin
                state <= ST_IDLE;
              end
            end
          end

          // Turnaround zero, sixteen data bits msb first, then release
          ST_RD: begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PID_TA_DRIVE) begin
              mdio_oe  <= 1'b1;
              mdio_out <= 1'b0;
            end else if (bit_cnt <= `PID_DATA_LAST_RD) begin
              mdio_out <= rd_sr[15];
              rd_sr    <= {rd_sr[14:0], 1'b0};
            end else begin
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b0;
              bit_cnt  <= 5'h00;
              state    <= ST_IDLE;
            end
          end

          // Two turnaround bits then sixteen data bits from the manager
          ST_WR: begin
            wr_sr   <= next_wr[14:0];
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `PID_FRAME_LAST) begin
              // Gating happens in the bank; frame ends the same way
              wr_data <= next_wr;
              wr_stb  <= 1'b1;
              bit_cnt <= 5'h00;
              state   <= ST_IDLE;
            end
          end

          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Identifier storage
  // ****************************************************************

  // Holds registers 2 and 3; writes pass the override gate there
  pid_id_bank #(
    .OUI   (OUI),
    .MODEL (MODEL),
    .REV   (REV)
  ) u_bank (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .clk_en          (clk_en),
    .wr_stb          (wr_stb),
    .wr_addr         (wr_addr),
    .wr_data         (wr_data),
    .cmd_override_en (cmd_override_en),
    .id_high         (id_high),
    .id_low          (id_low)
  );

endmodule

// [pid_phy_id_checker.sv]
// Purpose: Port checks of the identifier register block
// Assumes: Bound to the block's top module
// Notes:   Defaults rebuilt from the identity parameters
`timescale 1ns/1ns
`include "pid_defines.vh"
module pid_phy_id_checker #(
  parameter [23:0] OUI   = `PID_OUI_DEFAULT,
  parameter [5:0]  MODEL = `PID_MODEL_DEFAULT,
  parameter [3:0]  REV   = `PID_REV_DEFAULT
) (
  input wire        clk,
  input wire        sys_rst,
  input wire        clk_en,
  input wire        mdc,
  input wire        mdio_in,
  input wire        mdio_out,
  input wire        mdio_oe,
  input wire [4:0]  phy_addr,
  input wire        cmd_override_en,
  input wire [15:0] id_high,
  input wire [15:0] id_low
);
`include "pid_exp.svh"
  // ****************
  // Rise tracking
  // ****************
  reg       mdc_q;
  reg [4:0] rises;
  wire      rise = clk_en && mdc && !mdc_q;
  // Count mdc rises while the block drives the pin
  always @(posedge clk) begin
    if (sys_rst) begin
      mdc_q <= 1'b0;
      rises <= 5'h00;
    end else if (clk_en) begin
      mdc_q <= mdc;
      rises <= mdio_oe ? rises + {4'h0, rise} : 5'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_drive_on;
    $rose(mdio_oe) && !$past(sys_rst);
  endsequence
  sequence s_released;
    $fell(mdio_oe) && !$past(sys_rst);
  endsequence
  hi_default_a:
    assert property ($fell(sys_rst) |-> id_high == pid_oui_bits(OUI, 3, 16))
    else $error("id_high default wrong");
  lo_oui_a:
    assert property ($fell(sys_rst) |->
      {id_low[15:10], 10'h000} == pid_oui_bits(OUI, 19, 6))
    else $error("id_low identifier bits wrong");
  model_field_a:
    assert property ($fell(sys_rst) |-> id_low[9:4] == MODEL)
    else $error("model field wrong");
  rev_field_a:
    assert property ($fell(sys_rst) |-> id_low[3:0] == REV)
    else $error("revision field wrong");
  pin_idle_a:
    assert property ($fell(sys_rst) |-> !mdio_oe [*2])
    else $error("pin driven after reset");
  id_locked_a:
    assert property (!cmd_override_en |=> $stable(id_high) && $stable(id_low))
    else $error("identifier changed without override");
  ta_zero_a:
    assert property (s_drive_on |-> !mdio_out)
    else $error("turnaround bit not zero");
  read_len_a:
    assert property (s_released |-> rises == 5'h11)
    else $error("read data length wrong");
  out_hold_a:
    assert property ($changed(mdio_out) && !$past(sys_rst) |-> $past(rise))
    else $error("data changed off an mdc rise");
endmodule
bind pid_phy_id pid_phy_id_checker #(.OUI(OUI), .MODEL(MODEL), .REV(REV)) chk (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .mdc(mdc),
  .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
  .phy_addr(phy_addr), .cmd_override_en(cmd_override_en),
  .id_high(id_high), .id_low(id_low));

// [pid_sta_model.sv]
// Purpose: Management station driving serial frames
// Assumes: Pin level resolved by the bench, pulled up
// Notes:   mdc stands low between frames
`timescale 1ns/1ns
module pid_sta_model (
  input  wire clk,
  input  wire mdio_wire,
  output reg  mdc,
  output reg  mdio_drv,
  output reg  mdio_en
);
  initial begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
    mdio_en = 1'b0;
  end
  // One bit slot; the pin is sampled at the end of the high phase
  task automatic clk_bit(input b, input en, input integer half, output s);
    begin
      mdio_drv <= b;
      mdio_en <= en;
      repeat (half) @(posedge clk);
      mdc <= 1'b1;
      repeat (half) @(posedge clk);
      s = mdio_wire;
      mdc <= 1'b0;
    end
  endtask
  // Whole frame; the pin is released after the header of a read
  task automatic frame(input [13:0] hdr, input [15:0] wd,
    input integer pre, input integer half, output [17:0] rx);
    integer i;
    reg s;
    reg [17:0] w;
    begin
      w = {2'b10, wd};
      @(posedge clk);
      for (i = 0; i < pre; i = i + 1)
        clk_bit(1'b1, 1'b1, half, s);
      for (i = 13; i >= 0; i = i - 1)
        clk_bit(hdr[i], 1'b1, half, s);
      for (i = 17; i >= 0; i = i - 1) begin
        clk_bit(w[i], hdr[11:10] == 2'h1, half, s);
        rx[i] = s;
      end
      mdio_en <= 1'b0;
    end
  endtask
endmodule

// [test_pid_phy_id.sv]
// Purpose: Self-checking bench of the identifier registers
// Assumes: Default identity parameters
// Notes:   Registers written only through serial frames; read by frames and at the ports
`timescale 1ns/1ns
`include "pid_defines.vh"
module test_pid_phy_id;
`include "pid_exp.svh"
  localparam [4:0] PHY = 5'h0b;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         clk_en = 1'b1;
  reg         cmd_override_en = 1'b0;
  reg  [4:0]  phy_addr = PHY;
  wire        mdc;
  wire        drv;
  wire        en;
  wire        mdio_out;
  wire        mdio_oe;
  wire [15:0] id_high;
  wire [15:0] id_low;
  wire        mdio = (mdio_oe === 1'b1) ? mdio_out : (en ? drv : 1'b1);
  integer     mismatches = 0;
  integer     comparisons = 0;
  reg  [15:0] exp_h;
  reg  [15:0] exp_l;
  reg  [17:0] rx;
  always #5 clk = ~clk;
  pid_phy_id uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_addr(phy_addr), .cmd_override_en(cmd_override_en),
    .id_high(id_high), .id_low(id_low));
  pid_sta_model sta (.clk(clk), .mdio_wire(mdio), .mdc(mdc),
    .mdio_drv(drv), .mdio_en(en));
  task check(input [15:0] seen, input [15:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task rd(input [4:0] ph, input [4:0] rg, input integer half,
    output [15:0] d);
    begin
      sta.frame({2'b01, `PID_OP_READ, ph, rg}, 16'h0000, 32, half, rx);
      check({15'h0000, rx[17]}, {15'h0000, ph != PHY});
      d = rx[16:1];
    end
  endtask
  task wr(input [4:0] rg, input [15:0] d, input integer pre);
    begin
      sta.frame({2'b01, `PID_OP_WRITE, PHY, rg}, d, pre, 2, rx);
      repeat (3) @(posedge clk);
    end
  endtask
  task t_defaults;
    reg [15:0] d;
    begin
      check(id_high, exp_h);
      check(id_low, exp_l);
      check(id_high, 16'h68f1);
      check(id_low, 16'ha6a3);
      rd(PHY, `PID_REG_ID_HIGH, 2, d);
      check(d, exp_h);
      rd(PHY, `PID_REG_ID_LOW, 5, d);
      check(d, exp_l);
      rd(PHY, `PID_REG_STATUS, 2, d);
      check(d, 16'h0001);
      rd(PHY, 5'h04, 2, d);
      check(d, 16'h0000);
      $display("end of defaults test");
    end
  endtask
  task t_blocked;
    reg [15:0] d;
    begin
      wr(`PID_REG_ID_HIGH, ~exp_h, 32);
      wr(`PID_REG_ID_LOW, ~exp_l, 32);
      rd(PHY, `PID_REG_ID_HIGH, 2, d);
      check(d, exp_h);
      check(id_low, exp_l);
      $display("end of blocked write test");
    end
  endtask
  task t_gated;
    reg [15:0] d;
    begin
      cmd_override_en <= 1'b1;
      wr(`PID_REG_ID_HIGH, 16'ha5c3, 32);
      wr(`PID_REG_ID_LOW, 16'h3c5a, 32);
      cmd_override_en <= 1'b0;
      rd(PHY, `PID_REG_ID_HIGH, 5, d);
      check(d, 16'ha5c3);
      check(id_low, 16'h3c5a);
      // Short preamble and foreign address are ignored
      cmd_override_en <= 1'b1;
      wr(`PID_REG_ID_HIGH, 16'h0f0f, 31);
      check(id_high, 16'ha5c3);
      cmd_override_en <= 1'b0;
      rd(5'h0a, `PID_REG_ID_HIGH, 2, d);
      check(d, 16'hffff);
      $display("end of gated write test");
    end
  endtask
  task t_reset2;
    begin
      // Frozen block lets a whole write frame pass unseen
      cmd_override_en <= 1'b1;
      clk_en <= 1'b0;
      wr(`PID_REG_ID_HIGH, 16'h1234, 32);
      check(id_high, 16'ha5c3);
      cmd_override_en <= 1'b0;
      clk_en <= 1'b1;
      @(posedge clk);
      clk_en <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      clk_en <= 1'b1;
      @(posedge clk);
      check(id_high, exp_h);
      check(id_low, exp_l);
      repeat (2) @(posedge clk);
      $display("end of second reset test");
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  initial begin
    exp_h = pid_oui_bits(`PID_OUI_DEFAULT, 3, 16);
    exp_l = pid_oui_bits(`PID_OUI_DEFAULT, 19, 6)
          | {6'h00, `PID_MODEL_DEFAULT, `PID_REV_DEFAULT};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_defaults;
    t_blocked;
    t_gated;
    t_reset2;
    print_verdict;
  end
  // Watchdog far beyond the expected run
  initial begin
    #300000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
